/* core/nand_seq_pkg.sv */
// Shared constants and types for the flash cache-operation sequencer.
// Assumes a 40 MHz core clock; all times are converted to cycle counts here.
package nand_seq_pkg;

  // ---------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 40;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ1       = 8'h00;
  localparam logic [7:0] CMD_READ2       = 8'h30;
  localparam logic [7:0] CMD_READ_CACHE  = 8'h31;
  localparam logic [7:0] CMD_READ_LAST   = 8'h3F;
  localparam logic [7:0] CMD_COPY_READ   = 8'h3A;
  localparam logic [7:0] CMD_DATA_IN     = 8'h80;
  localparam logic [7:0] CMD_DATA_IN2    = 8'h81;
  localparam logic [7:0] CMD_PROG        = 8'h10;
  localparam logic [7:0] CMD_PROG_PLANE  = 8'h11;
  localparam logic [7:0] CMD_PROG_CACHE  = 8'h15;
  localparam logic [7:0] CMD_ERASE1      = 8'h60;
  localparam logic [7:0] CMD_ERASE2      = 8'hD0;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_RESET       = 8'hFF;

  // ---------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------
  localparam int STAT_READY_BIT = 6;
  localparam int STAT_FAIL_BIT  = 0;

  // ---------------------------------------------------------------
  // Busy limits (us) and derived cycle counts, rounded down
  // ---------------------------------------------------------------
  localparam int CACHE_WRITE_BUSY_SHORT_US = 10;
  localparam int CACHE_WRITE_BUSY_LONG_US  = 700;
  localparam int PROG_TIME_US              = 700;
  localparam int ARRAY_FETCH_TIME_US       = 25;
  localparam int CACHE_READ_BUSY_TIME_US   = 25;
  localparam int PAGE_COPY_BUSY_TIME_US    = 30;
  localparam int BLOCK_ERASE_BUSY_TIME_US  = 5000;
  localparam int RESET_BUSY_US             = 500;
  localparam int CACHE_WRITE_BUSY_SHORT_CYC = CACHE_WRITE_BUSY_SHORT_US * CLK_MHZ;
  localparam int CACHE_WRITE_BUSY_LONG_CYC  = CACHE_WRITE_BUSY_LONG_US * CLK_MHZ;
  localparam int PROG_TIME_CYC              = PROG_TIME_US * CLK_MHZ;
  localparam int ARRAY_FETCH_TIME_CYC       = ARRAY_FETCH_TIME_US * CLK_MHZ;
  localparam int CACHE_READ_BUSY_TIME_CYC   = CACHE_READ_BUSY_TIME_US * CLK_MHZ;
  localparam int PAGE_COPY_BUSY_TIME_CYC    = PAGE_COPY_BUSY_TIME_US * CLK_MHZ;
  localparam int BLOCK_ERASE_BUSY_TIME_CYC  = BLOCK_ERASE_BUSY_TIME_US * CLK_MHZ;
  localparam int RESET_BUSY_CYC             = RESET_BUSY_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Pin cycle timing: each bus phase lasts this many clocks
  // ---------------------------------------------------------------
  localparam int STROBE_LOW_CYC  = 1;
  localparam int STROBE_HIGH_CYC = 1;
  localparam int TURNAROUND_CYC  = 3;  // Covers WE-high-to-RE-low 60 ns
  localparam logic [2:0] STRB_CNT_W = 3'h0;

  // ---------------------------------------------------------------
  // Page geometry, limits
  // ---------------------------------------------------------------
  localparam int MAX_PARTIAL_PROG = 4;
  localparam int ADDR_CYCLES      = 5;
  localparam int TIMER_W          = 24;
  localparam int BUF_DEPTH        = 2;

  // ---------------------------------------------------------------
  // Host operation codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ, OP_READ_CACHE, OP_READ_LAST, OP_COPY_READ,
    OP_PROG, OP_PROG_CACHE, OP_PROG_PLANE, OP_ERASE
  } op_t;

  typedef enum logic [1:0] {
    RES_OK, RES_FAIL, RES_TIMEOUT, RES_REFUSED
  } result_t;

endpackage : nand_seq_pkg

/* core/byte_stream_if.sv */
// Valid/ready byte stream carrier between the sequencer and its buffer.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

/* core/skid_buffer2.sv */
// Two-entry valid/ready buffer for read data.
// Assumes a single clock and active-low asynchronous reset.
`timescale 1ns/1ps
module skid_buffer2
  import nand_seq_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   rst_b,
  byte_stream_if.snk  inS,
  byte_stream_if.src  outS
);

  typedef struct packed {
    logic [BUF_DEPTH-1:0][7:0] mem;
    logic                      wrPtr;
    logic                      rdPtr;
    logic [1:0]                count;
  } buf_state_t;

  buf_state_t st_r;
  buf_state_t st_nxt;
  logic       push;
  logic       pop;

  assign inS.ready  = (st_r.count != 2'h2);
  assign outS.valid = (st_r.count != 2'h0);
  assign outS.data  = st_r.mem[st_r.rdPtr];
  assign push       = inS.valid && inS.ready;
  assign pop        = outS.valid && outS.ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wrPtr] = inS.data;
      st_nxt.wrPtr           = ~st_r.wrPtr;
    end
    if (pop) begin
      st_nxt.rdPtr = ~st_r.rdPtr;
    end
    st_nxt.count = 2'(st_r.count + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : skid_buffer2

/* core/nand_cache_sequencer.sv */
// Host-side sequencer driving an 8-bit asynchronous flash over its pins.
// Assumes pins are wired directly; ready_busy_n and I/O inputs are asynchronous.
//
// Overview of operation
// - Refuse a fifth partial program of one page before block erase.
// - Single-plane cache series ends with 80h then 10h.
// - Series ended 80h/15h: poll status 70h until bit 6 ready.
// - Multi-page cache series ends with 81h then 10h; the code ends OP_PROG_PLANE with 81h then 11h.
// - Series ended 81h/15h: poll status as for single plane.
// - After a 15h-ended series completes, send reset FFh first.
// - Never drive I/O bus while device outputs data.
// - Cache program uses 80h then 15h; normal program 80h then 10h.
`timescale 1ns/1ps
module nand_cache_sequencer
  import nand_seq_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire op_t         reqOp,
  input  wire logic [39:0] reqAddr,
  input  wire logic [11:0] reqLen,
  input  wire logic        wrValid,
  output logic             wrReady,
  input  wire logic [7:0]  wrData,
  output logic             rdValid,
  input  wire logic        rdReady,
  output logic [7:0]       rdData,
  output logic             doneValid,
  output result_t          doneResult,
  output logic             cacheOpen,
  output logic             cle,
  output logic             ale,
  output logic             chipSel_n,
  output logic             writeStrobe_n,
  output logic             output_strobe_n,
  output logic [7:0]       ioOut,
  output logic             ioOe_n,
  input  wire logic [7:0]  ioIn,
  input  wire logic        ready_busy_n
);

  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_DATA, S_CMD2, S_BUSY, S_STAT_CMD, S_STAT_RD,
    S_READ, S_RESET, S_DONE
  } state_t;

  typedef struct packed {
    state_t              st;
    op_t                 op;
    logic [39:0]         addr;
    logic [2:0]          addrIdx;
    logic [11:0]         len;
    logic [TIMER_W-1:0]  timer;
    logic [1:0]          phase;
    logic                polling;
    logic                needReset;
    logic                cacheOpen;
    logic [39:0]         lastPage;
    logic [2:0]          partialCnt;
    logic                reqReady;
    logic                wrReady;
    logic                doneValid;
    result_t             doneResult;
    logic                cle;
    logic                ale;
    logic                chipSel_n;
    logic                writeStrobe_n;
    logic                readStrobe_n;
    logic [7:0]          ioOut;
    logic                ioOe_n;
    logic [1:0]          rbSync;
    logic [7:0]          ioSync1;
    logic [7:0]          ioSync2;
  } seq_state_t;

  seq_state_t    s_r;
  seq_state_t    s_nxt;
  byte_stream_if rdIn ();
  byte_stream_if rdOut ();

  // ---------------------------------------------------------------
  // Read data buffer
  // ---------------------------------------------------------------
  skid_buffer2 u_buf (.core_clk(core_clk), .rst_b(rst_b), .inS(rdIn.snk), .outS(rdOut.src));
  // Pop only when the output register is free or being drained
  assign rdOut.ready = !rdVal_r || rdReady;

  logic [7:0] rdHold_r;
  logic       rdVal_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdHold_r <= 8'h00;
      rdVal_r  <= 1'b0;
    end else if (!rdVal_r || rdReady) begin
      rdVal_r  <= rdOut.valid;
      rdHold_r <= rdOut.data;
    end
  end
  assign rdValid = rdVal_r;
  assign rdData  = rdHold_r;

  logic [TIMER_W-1:0] busyLimit;
  logic               rbReady;
  logic [7:0]         secondCmd;
  logic               pushRead;

  assign rbReady = s_r.rbSync[1];
  // Synchronised byte is settled in phase 3; room was checked before the strobe
  assign pushRead = (s_r.st == S_READ) && (s_r.phase == 2'h3);
  assign rdIn.valid = pushRead;
  assign rdIn.data  = s_r.ioSync2;

  always_comb begin
    unique case (s_r.op)
      OP_READ:       busyLimit = TIMER_W'(ARRAY_FETCH_TIME_CYC);
      OP_READ_CACHE,
      OP_READ_LAST:  busyLimit = TIMER_W'(CACHE_READ_BUSY_TIME_CYC);
      OP_COPY_READ:  busyLimit = TIMER_W'(PAGE_COPY_BUSY_TIME_CYC);
      OP_PROG_CACHE: busyLimit = TIMER_W'(CACHE_WRITE_BUSY_LONG_CYC);
      OP_PROG_PLANE: busyLimit = TIMER_W'(CACHE_WRITE_BUSY_SHORT_CYC);
      OP_PROG:       busyLimit = TIMER_W'(2 * PROG_TIME_CYC);
      OP_ERASE:      busyLimit = TIMER_W'(BLOCK_ERASE_BUSY_TIME_CYC);
    endcase
    unique case (s_r.op)
      OP_READ:       secondCmd = CMD_READ2;
      OP_READ_CACHE: secondCmd = CMD_READ_CACHE;
      OP_READ_LAST:  secondCmd = CMD_READ_LAST;
      OP_COPY_READ:  secondCmd = CMD_COPY_READ;
      OP_PROG_CACHE: secondCmd = CMD_PROG_CACHE;
      OP_PROG_PLANE: secondCmd = CMD_PROG_PLANE;
      OP_PROG:       secondCmd = CMD_PROG;
      OP_ERASE:      secondCmd = CMD_ERASE2;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rbSync  = {s_r.rbSync[0], ready_busy_n};
    s_nxt.ioSync1 = ioIn;
    s_nxt.ioSync2 = s_r.ioSync1;
    s_nxt.doneValid = 1'b0;
    s_nxt.reqReady  = 1'b0;
    s_nxt.wrReady   = 1'b0;
    s_nxt.cle = 1'b0;
    s_nxt.ale = 1'b0;
    s_nxt.writeStrobe_n = 1'b1;
    s_nxt.readStrobe_n  = 1'b1;
    s_nxt.phase = 2'(s_r.phase + 2'h1);
    unique case (s_r.st)
      S_IDLE: begin
        s_nxt.chipSel_n = 1'b1;
        s_nxt.ioOe_n    = 1'b1;
        s_nxt.phase     = 2'h0;
        if (s_r.needReset) begin
          s_nxt.st        = S_RESET;
          s_nxt.chipSel_n = 1'b0;
        end else if (reqValid && !s_r.reqReady) begin
          s_nxt.reqReady = 1'b1;
          s_nxt.op   = reqOp;
          s_nxt.addr = reqAddr;
          s_nxt.len  = reqLen;
          s_nxt.addrIdx = 3'h0;
          if (reqOp inside {OP_PROG, OP_PROG_CACHE, OP_PROG_PLANE} &&
              reqAddr[39:16] == s_r.lastPage[39:16] &&
              s_r.partialCnt == 3'(MAX_PARTIAL_PROG)) begin
            s_nxt.doneValid  = 1'b1;
            s_nxt.doneResult = RES_REFUSED;
          end else begin
            s_nxt.chipSel_n = 1'b0;
            s_nxt.st = (reqOp inside {OP_READ_CACHE, OP_READ_LAST}) ? S_CMD2 : S_CMD1;
          end
        end
      end
      S_CMD1, S_CMD2, S_RESET, S_STAT_CMD: begin
        s_nxt.ioOe_n = 1'b0;
        s_nxt.cle    = (s_r.phase != 2'h3);
        s_nxt.writeStrobe_n = (s_r.phase != 2'h1);
        unique case (s_r.st)
          S_CMD1: s_nxt.ioOut = (s_r.op inside {OP_PROG, OP_PROG_CACHE}) ? CMD_DATA_IN :
                                (s_r.op == OP_PROG_PLANE) ? CMD_DATA_IN2 :
                                (s_r.op == OP_ERASE) ? CMD_ERASE1 : CMD_READ1;
          S_CMD2:     s_nxt.ioOut = secondCmd;
          S_RESET:    s_nxt.ioOut = CMD_RESET;
          S_STAT_CMD: s_nxt.ioOut = CMD_STATUS;
          default:    s_nxt.ioOut = 8'h00;
        endcase
        if (s_r.phase == 2'h3) begin
          s_nxt.timer = '0;
          unique case (s_r.st)
            S_CMD1:     s_nxt.st = S_ADDR;
            S_CMD2:     s_nxt.st = S_BUSY;
            S_RESET:    s_nxt.st = S_BUSY;
            S_STAT_CMD: s_nxt.st = S_STAT_RD;
            default:    s_nxt.st = S_IDLE;
          endcase
          if (s_r.st == S_RESET) begin
            s_nxt.needReset = 1'b0;
            s_nxt.polling   = 1'b1;
          end
          if (s_r.st == S_CMD2 && s_r.op == OP_READ_CACHE) begin
            s_nxt.addr[11:0] = 12'h000;
          end
        end
      end
      S_ADDR: begin
        s_nxt.ioOe_n = 1'b0;
        s_nxt.ale    = (s_r.phase != 2'h3);
        s_nxt.writeStrobe_n = (s_r.phase != 2'h1);
        s_nxt.ioOut  = s_r.addr[8*s_r.addrIdx +: 8];
        if (s_r.phase == 2'h3) begin
          s_nxt.addrIdx = 3'(s_r.addrIdx + 3'h1);
          if ((s_r.op == OP_ERASE && s_r.addrIdx == 3'h4) || s_r.addrIdx == 3'(ADDR_CYCLES - 1)) begin
            s_nxt.st = (s_r.op inside {OP_PROG, OP_PROG_CACHE, OP_PROG_PLANE}) ? S_DATA : S_CMD2;
          end else if (s_r.op == OP_ERASE && s_r.addrIdx == 3'h0) begin
            s_nxt.addrIdx = 3'h2;
          end
        end
      end
      S_DATA: begin
        s_nxt.ioOe_n = 1'b0;
        s_nxt.phase  = s_r.phase;
        if (s_r.len == 12'h000) begin
          s_nxt.st = S_CMD2;
          s_nxt.phase = 2'h0;
        end else if (s_r.phase == 2'h0) begin
          s_nxt.wrReady = 1'b1;
          if (wrValid && s_r.wrReady) begin
            s_nxt.wrReady = 1'b0;
            s_nxt.ioOut = wrData;
            s_nxt.writeStrobe_n = 1'b0;
            s_nxt.phase = 2'h1;
          end
        end else begin
          s_nxt.phase = 2'h0;
          s_nxt.len = 12'(s_r.len - 12'h001);
        end
      end
      S_BUSY: begin
        s_nxt.ioOe_n = 1'b1;
        s_nxt.timer = TIMER_W'(s_r.timer + 1'b1);
        if (s_r.timer > 2 && rbReady) begin
          s_nxt.phase = 2'h0;
          if (s_r.polling) begin
            // Automatic reset finished: no result reported
            s_nxt.polling   = 1'b0;
            s_nxt.chipSel_n = 1'b1;
            s_nxt.st        = S_IDLE;
          end else if (s_r.op inside {OP_PROG, OP_PROG_CACHE, OP_PROG_PLANE, OP_ERASE}) begin
            s_nxt.st = S_STAT_CMD;
          end else begin
            s_nxt.st = S_READ;
          end
        end else if (s_r.timer >= busyLimit + TIMER_W'(RESET_BUSY_CYC)) begin
          if (s_r.polling) begin
            s_nxt.polling   = 1'b0;
            s_nxt.chipSel_n = 1'b1;
            s_nxt.st        = S_IDLE;
          end else begin
            s_nxt.st = S_DONE;
            s_nxt.doneResult = RES_TIMEOUT;
          end
        end
      end
      S_STAT_RD: begin
        s_nxt.ioOe_n = 1'b1;
        s_nxt.readStrobe_n = (s_r.phase != 2'h0);
        if (s_r.phase == 2'h3) begin
          if (s_r.ioSync2[STAT_READY_BIT] == 1'b0) begin
            s_nxt.st = S_STAT_CMD;
          end else begin
            s_nxt.st = S_DONE;
            s_nxt.chipSel_n = 1'b1;
            s_nxt.doneResult = s_r.ioSync2[STAT_FAIL_BIT] ? RES_FAIL : RES_OK;
          end
        end
      end
      S_READ: begin
        s_nxt.ioOe_n = 1'b1;
        // Strobe only with buffer room, so a stall never drops a byte
        s_nxt.readStrobe_n = !(s_r.phase == 2'h0 && rdIn.ready && s_r.len != 12'h000);
        if (s_r.len == 12'h000) begin
          s_nxt.st = S_DONE;
          s_nxt.doneResult = RES_OK;
          s_nxt.chipSel_n = 1'b1;
        end else if (s_r.phase == 2'h0 && !rdIn.ready) begin
          s_nxt.phase = s_r.phase;
        end else if (s_r.phase == 2'h3) begin
          s_nxt.len = 12'(s_r.len - 12'h001);
          if (s_r.len <= 12'h001) begin
            s_nxt.st = S_DONE;
            s_nxt.doneResult = RES_OK;
            s_nxt.chipSel_n = 1'b1;
          end
        end
      end
      S_DONE: begin
        s_nxt.doneValid = 1'b1;
        s_nxt.chipSel_n = 1'b1;
        s_nxt.st = S_IDLE;
        if (s_r.op inside {OP_PROG, OP_PROG_CACHE, OP_PROG_PLANE}) begin
          s_nxt.partialCnt = (s_r.addr[39:16] == s_r.lastPage[39:16]) ?
                             3'(s_r.partialCnt + 3'h1) : 3'h1;
          s_nxt.lastPage = s_r.addr;
        end else if (s_r.op == OP_ERASE && s_r.addr[39:22] == s_r.lastPage[39:22]) begin
          s_nxt.partialCnt = 3'h0;
        end
        s_nxt.cacheOpen = (s_r.op == OP_PROG_CACHE);
        s_nxt.needReset = (s_r.op == OP_PROG_CACHE);
        if (s_r.doneResult == RES_TIMEOUT) begin
          s_nxt.needReset = 1'b1;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{st: S_IDLE, op: OP_READ, chipSel_n: 1'b1, writeStrobe_n: 1'b1,
               readStrobe_n: 1'b1, ioOe_n: 1'b1, doneResult: RES_OK, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reqReady        = s_r.reqReady;
  assign wrReady         = s_r.wrReady;
  assign doneValid       = s_r.doneValid;
  assign doneResult      = s_r.doneResult;
  assign cacheOpen       = s_r.cacheOpen;
  assign cle             = s_r.cle;
  assign ale             = s_r.ale;
  assign chipSel_n       = s_r.chipSel_n;
  assign writeStrobe_n   = s_r.writeStrobe_n;
  assign output_strobe_n = s_r.readStrobe_n;
  assign ioOut           = s_r.ioOut;
  assign ioOe_n          = s_r.ioOe_n;

endmodule : nand_cache_sequencer

/* sim/nand_seq_properties.sv */
// Pin and handshake checks for the flash cache-operation sequencer.
// Assumes binding to the sequencer top ports, one clock domain.
`timescale 1ns/1ps
module nand_seq_properties
  import nand_seq_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       doneValid,
  input wire result_t    doneResult,
  input wire logic       cacheOpen,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       chipSel_n,
  input wire logic       writeStrobe_n,
  input wire logic       output_strobe_n,
  input wire logic [7:0] ioOut,
  input wire logic       ioOe_n,
  input wire logic       ready_busy_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] lastCmd_r;
  logic       rstDue_r;
  sequence cmdLatch;
    cle && $rose(writeStrobe_n);
  endsequence
  sequence busyLong;
    !ready_busy_n [*3];
  endsequence
  // Previous latched command, pending reset after a cache series
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lastCmd_r <= 8'h00;
      rstDue_r  <= 1'b0;
    end else begin
      if (cle && $rose(writeStrobe_n)) lastCmd_r <= ioOut;
      rstDue_r <= (doneValid && cacheOpen) || (rstDue_r && !(cle && $rose(writeStrobe_n)));
    end
  end
  a_bus_no_clash: assert property (!output_strobe_n |-> ioOe_n)
    else $error("controller drives bus during read strobe");
  a_latch_excl: assert property (!(cle && ale) && !(!writeStrobe_n && !output_strobe_n))
    else $error("latch or strobe overlap");
  a_cmd_drive: assert property (cle && !writeStrobe_n |-> !ioOe_n && !chipSel_n)
    else $error("command strobed without bus drive");
  a_done_pulse: assert property (doneValid |=> !doneValid)
    else $error("done pulse longer than one cycle");
  a_refuse_quiet: assert property (doneValid && doneResult == RES_REFUSED |-> $past(chipSel_n, 1) && $past(chipSel_n, 3))
    else $error("refused program touched the pins");
  a_poll_status: assert property (cmdLatch ##0 (lastCmd_r inside {8'h10, 8'h15, 8'hD0}) |-> ioOut == 8'h70)
    else $error("no status read after program confirm");
  a_reset_first: assert property (cmdLatch ##0 rstDue_r |-> ioOut == 8'hFF)
    else $error("cache series not followed by reset");
  a_busy_hold: assert property (busyLong |-> output_strobe_n && (writeStrobe_n || cle))
    else $error("data or address strobed while busy");
endmodule : nand_seq_properties

/* sim/flash_model.sv */
// Behavioural flash device answering the sequencer's pins.
// Assumes a 1 ns time unit; busy length comes from busyNs, except a fixed 2000 ns after reset FFh.
`timescale 1ns/1ps
module flash_model (
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        chipSel_n,
  input  wire logic        writeStrobe_n,
  input  wire logic        output_strobe_n,
  input  wire logic [7:0]  ioOut,
  input  wire logic        ioOe_n,
  input  wire logic [31:0] busyNs,
  input  wire logic        failNext,
  output logic [7:0]       ioIn,
  output logic             ready_busy_n
);
  logic [7:0] mem [256];
  logic [7:0] col, lastOut;
  logic       statMode, busy;
  int         tok, addrCnt;
  assign ready_busy_n = !busy;
  task automatic goBusy(input int ns);
    int t;
    tok++;
    t = tok;
    busy = 1'b1;
    fork
      begin
        #(ns);
        if (t == tok) busy = 1'b0;
      end
    join_none
  endtask : goBusy
  initial begin
    busy = 1'b0; tok = 0; addrCnt = 0; col = 8'h00; statMode = 1'b0; ioIn = 8'h5A; lastOut = 8'hA5;
  end
  always @(posedge writeStrobe_n) begin
    if (!chipSel_n && cle) begin
      statMode = (ioOut == 8'h70);
      addrCnt = 0;
      if (ioOut == 8'h31) col = 8'h00;
      if (ioOut inside {8'h10, 8'h15, 8'h11, 8'h30, 8'h31, 8'h3F, 8'h3A, 8'hD0}) goBusy(busyNs);
      if (ioOut == 8'hFF) goBusy(2000);
    end else if (!chipSel_n && ale) begin
      if (addrCnt == 0) col = ioOut;
      addrCnt++;
    end else if (!chipSel_n && !ioOe_n) begin
      mem[col] = ioOut;
      col++;
    end
  end
  always @(negedge output_strobe_n) begin
    if (!chipSel_n) begin
      lastOut = statMode ? {1'b0, !busy, 5'h00, failNext} : mem[col];
      if (!statMode) col++;
      #20 ioIn = lastOut;
    end
  end
  // Outputs float after the strobe rises; scramble instead of holding
  always @(posedge output_strobe_n) begin
    #26 ioIn = ~lastOut;
  end
endmodule : flash_model

/* sim/tb_nand_cache_sequencer.sv */
// Self-checking bench for the flash cache-operation sequencer.
// Assumes flash_model on the pins and the property checker bound below.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_nand_cache_sequencer
  import nand_seq_pkg::*;
;
  localparam logic [39:0] PAGE_A = 40'h00_0005_0000;
  localparam logic [39:0] PAGE_B = 40'h00_0009_0000;
  logic        core_clk, rst_b, reqValid, reqReady, wrValid, wrReady, rdValid, rdReady;
  logic        doneValid, cacheOpen, cle, ale, chipSel_n, writeStrobe_n, output_strobe_n;
  logic        ioOe_n, ready_busy_n, failNext;
  op_t         reqOp;
  result_t     doneResult, expR;
  logic [39:0] reqAddr;
  logic [11:0] reqLen;
  logic [7:0]  wrData, rdData, ioOut, ioIn, expB;
  logic [31:0] busyNs;
  int          mismatches, checks_done, wrIdx, wrCnt;
  logic [7:0]  wrBuf [256];
  logic [7:0]  pageExp [8];
  logic [7:0]  rdQ [$];
  result_t     resQ [$];
  nand_cache_sequencer uut (.core_clk, .rst_b, .reqValid, .reqReady, .reqOp, .reqAddr, .reqLen,
    .wrValid, .wrReady, .wrData, .rdValid, .rdReady, .rdData, .doneValid, .doneResult, .cacheOpen,
    .cle, .ale, .chipSel_n, .writeStrobe_n, .output_strobe_n, .ioOut, .ioOe_n, .ioIn, .ready_busy_n);
  flash_model dev (.cle, .ale, .chipSel_n, .writeStrobe_n, .output_strobe_n, .ioOut, .ioOe_n,
    .busyNs, .failNext, .ioIn, .ready_busy_n);
  always #12.5 core_clk = ~core_clk;
  // ------------------------------------------------------------
  // Stream drivers and result monitor
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (wrValid && wrReady) wrIdx++;
    wrValid <= (wrIdx < wrCnt);
    wrData  <= wrBuf[wrIdx[7:0]];
    rdReady <= ($urandom_range(0, 3) != 0);
  end
  always @(posedge core_clk) begin
    if (rdValid === 1'b1 && rdReady === 1'b1) begin
      expB = rdQ.size() ? rdQ.pop_front() : 8'hXX;
      `CHK("rdData", expB, rdData)
    end
    if (doneValid === 1'b1) begin
      expR = resQ.size() ? resQ.pop_front() : result_t'(2'bXX);
      `CHK("doneResult", expR, doneResult)
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic doOp(input op_t op, input logic [39:0] ad, input int len, input result_t res);
    int n;
    reqOp    <= op;
    reqAddr  <= ad;
    reqLen   <= 12'(len);
    reqValid <= 1'b1;
    resQ.push_back(res);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (reqReady === 1'b1) reqValid <= 1'b0;
    end while (doneValid !== 1'b1 && n < 30000);
    if (n >= 30000) begin
      mismatches++;
      end_sim();
    end
    $display("test %s done", op.name());
  endtask : doOp
  task automatic prog(input op_t op, input logic [39:0] ad, input result_t res);
    if (res != RES_REFUSED) begin
      for (int i = 0; i < 8; i++) begin
        pageExp[i] = 8'($urandom);
        wrBuf[8'(wrCnt + i)] = pageExp[i];
      end
      wrCnt <= wrCnt + 8;
    end
    doOp(op, ad, 8, res);
  endtask : prog
  task automatic rd(input op_t op, input int c, input int n, input result_t res);
    if (res == RES_OK) for (int i = 0; i < n; i++) rdQ.push_back(pageExp[c + i]);
    doOp(op, PAGE_A | 40'(c), n, res);
  endtask : rd
  initial begin
    core_clk = 1'b0; rst_b = 1'b0; reqValid = 1'b0; reqOp = OP_READ; reqAddr = 40'h0; reqLen = 12'h0;
    wrValid = 1'b0; wrData = 8'h00; rdReady = 1'b0; failNext = 1'b0; busyNs = 32'd1000;
    mismatches = 0; checks_done = 0; wrIdx = 0; wrCnt = 0;
    void'($urandom(64));
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    prog(OP_PROG, PAGE_A, RES_OK);
    rd(OP_READ, 4, 4, RES_OK);
    prog(OP_PROG_CACHE, PAGE_A, RES_OK);
    rd(OP_READ_CACHE, 0, 4, RES_OK);
    prog(OP_PROG_PLANE, PAGE_A, RES_OK);
    prog(OP_PROG, PAGE_A, RES_OK);
    prog(OP_PROG, PAGE_A, RES_REFUSED);
    doOp(OP_ERASE, PAGE_A, 0, RES_OK);
    prog(OP_PROG, PAGE_A, RES_OK);
    rd(OP_READ_LAST, 0, 0, RES_OK);
    rd(OP_COPY_READ, 0, 0, RES_OK);
    failNext <= 1'b1;
    prog(OP_PROG, PAGE_B, RES_FAIL);
    failNext <= 1'b0;
    busyNs <= 32'd20000;
    rd(OP_READ, 0, 8, RES_OK);
    busyNs <= 32'd600000;
    rd(OP_READ, 0, 2, RES_TIMEOUT);
    busyNs <= 32'd1000;
    rd(OP_READ, 0, 8, RES_OK);
    end_sim();
  end
endmodule : tb_nand_cache_sequencer
bind nand_cache_sequencer nand_seq_properties chk (.core_clk, .rst_b, .doneValid, .doneResult, .cacheOpen,
  .cle, .ale, .chipSel_n, .writeStrobe_n, .output_strobe_n, .ioOut, .ioOe_n, .ready_busy_n);
